// file: include/remote_cmd_map.vh
// Register map, error codes and command codes of the remote command block.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
`ifndef REMOTE_CMD_MAP_VH
`define REMOTE_CMD_MAP_VH

// Register byte offsets
`define REG_CMD_OFS 4'h0
`define REG_CFG_OFS 4'h4
`define REG_STATUS_OFS 4'h8
`define REG_ERRQ_OFS 4'hC

// Command register field
`define CMD_CODE_MSB 3
`define CMD_ARG_BIT 8

// Command codes written to the command register
`define CMD_NONE 4'h0
`define CMD_INIT 4'h1
`define CMD_READ 4'h2
`define CMD_MEAS 4'h3
`define CMD_FETCH 4'h4
`define CMD_TRG 4'h5
`define CMD_CLS 4'h6
`define CMD_RST 4'h7
`define CMD_DCL 4'h8
`define CMD_TALK 4'h9
`define CMD_QUERY 4'hA
`define CMD_NULLREF 4'hB
`define CMD_EXPO 4'hC
`define CMD_CONF 4'hD
`define CMD_DONE 4'hE
`define CMD_BIGOUT 4'hF

// Configuration register fields
`define CFG_SRC_LSB 0
`define CFG_SRC_MSB 1
`define CFG_MATH_EN_BIT 2
`define CFG_MATH_OP_LSB 4
`define CFG_MATH_OP_MSB 6
`define CFG_FUNC_LSB 8
`define CFG_FUNC_MSB 11
`define CFG_LOCAL_BIT 12
`define CFG_AUTORANGE_BIT 13
`define CFG_FIXRES_BIT 14
`define CFG_SCNT_LSB 16
`define CFG_SCNT_MSB 23
`define CFG_TCNT_LSB 24
`define CFG_TCNT_MSB 31
`define CFG_RESET 32'h0000_2000

// Trigger sources
`define SRC_IMM 2'h0
`define SRC_BUS 2'h1
`define SRC_EXT 2'h2

// Functions that forbid math
`define FUNC_CONT 4'h8
`define FUNC_DIODE 4'h9
// Math operations valid only for voltage-like functions
`define MATH_DB 3'h5
`define MATH_DBM 3'h6

// Error codes, 16-bit signed
`define ERR_NONE 16'h0000
`define ERR_OVERFLOW_NUM 16'hFF85
`define ERR_TRG_IGN 16'hFF2D
`define ERR_TRG_DEADLOCK 16'hFF2B
`define ERR_INIT_IGN 16'hFF2A
`define ERR_CONFLICT 16'hFF23
`define ERR_STALE 16'hFF1A
`define ERR_TOO_MANY 16'hFEA2
`define ERR_Q_INTR 16'hFE66
`define ERR_Q_UNTERM 16'hFE5C
`define ERR_Q_DEADLOCK 16'hFE52
`define ERR_NO_MEM 16'h0213
`define ERR_OVLD_REF 16'h021C
`define ERR_LOCAL 16'h0226

// Limits
`define EXP_LIMIT 16'd32000
`define MEM_READINGS 17'd512
`define QUEUE_DEPTH 20

`endif

// file: hw/err_queue.v
// Error queue with overflow marker, first in first out.
// Assumes one push and one pop request at most per cycle.
`timescale 1ns/1ps
`include "remote_cmd_map.vh"
module err_queue #(
  parameter DEPTH = `QUEUE_DEPTH,
  parameter AW = 5
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire clr_i,
  input wire push_i,
  input wire [15:0] code_i,
  input wire pop_i,
  output reg [15:0] head_o,
  output reg nonempty_o,
  output reg new_err_o
);
  reg [15:0] mem [0:DEPTH-1];
  reg [AW-1:0] rd_reg;
  reg [AW-1:0] wr_reg;
  reg [AW:0] cnt_reg;
  reg full_lock_reg;
  localparam [AW-1:0] LAST_SLOT = DEPTH - 1;
  wire do_pop;
  wire do_push;
  wire [AW-1:0] rd_inc;
  wire [AW-1:0] wr_inc;
  wire [AW-1:0] last_ptr;

  assign do_pop = pop_i && (cnt_reg != {(AW+1){1'b0}});
  // Once overflowed nothing more goes in until a slot is freed
  assign do_push = push_i && !full_lock_reg;
  assign rd_inc = (rd_reg == DEPTH - 1) ? {AW{1'b0}} : rd_reg + 1'b1;
  assign wr_inc = (wr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_reg + 1'b1;
  assign last_ptr = (wr_reg == {AW{1'b0}}) ? LAST_SLOT : wr_reg - 1'b1;

  always @(posedge clk_sys_i) begin
    if (do_push && !clr_i) begin
      if (cnt_reg == DEPTH) begin
        mem[last_ptr] <= `ERR_TOO_MANY;
      end else begin
        mem[wr_reg] <= code_i;
      end
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_reg <= {AW{1'b0}};
      wr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      full_lock_reg <= 1'b0;
      new_err_o <= 1'b0;
    end else if (clr_i) begin
      rd_reg <= {AW{1'b0}};
      wr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      full_lock_reg <= 1'b0;
      new_err_o <= 1'b0;
    end else begin
      new_err_o <= push_i;
      if (do_pop) begin
        rd_reg <= rd_inc;
        full_lock_reg <= 1'b0;
      end
      if (do_push && cnt_reg == DEPTH && !do_pop) begin
        full_lock_reg <= 1'b1;
      end
      if (do_push && cnt_reg != DEPTH) begin
        wr_reg <= wr_inc;
      end
      if (do_push && cnt_reg != DEPTH && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !(do_push && cnt_reg != DEPTH)) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  always @* begin
    nonempty_o = (cnt_reg != {(AW+1){1'b0}});
    head_o = nonempty_o ? mem[rd_reg] : `ERR_NONE;
  end
endmodule

// file: hw/trig_ctrl.v
// Trigger arm state machine: idle, wait-for-trigger, measuring.
// Assumes one-cycle command pulses from the interpreter.
`timescale 1ns/1ps
module trig_ctrl (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire arm_i,
  input wire halt_i,
  input wire trig_i,
  input wire done_i,
  output reg waiting_o,
  output reg running_o,
  output reg start_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_MEAS = 2'd2;
  reg [1:0] state_reg;
  reg [1:0] state_next;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (arm_i) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trig_i) begin
          state_next = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (done_i) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (halt_i) begin
      state_next = ST_IDLE;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      start_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_o <= (state_reg == ST_WAIT) && trig_i && !halt_i;
    end
  end

  always @* begin
    waiting_o = (state_reg == ST_WAIT);
    running_o = (state_reg != ST_IDLE);
  end
endmodule

// file: hw/remote_cmd_error_trigger.v
// Remote command interpreter: trigger arming, error detection, error queue.
// Assumes an AXI4-Lite master and decoded commands written as codes.
`timescale 1ns/1ps
`include "remote_cmd_map.vh"
module remote_cmd_error_trigger (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_trig_i,
  input wire in_buf_full_i,
  output reg err_lamp_o,
  output reg beep_o,
  output reg meas_start_o,
  output reg to_output_o
);
  ////////////////////////////////////////////////////////////////////////
  reg [31:0] cfg_reg;
  reg [31:0] cmd_arg_reg;
  reg cmd_stb_reg;
  reg [3:0] cmd_code_reg;
  reg [9:0] mem_cnt_reg;
  reg out_pend_reg;
  reg meas_direct_reg;
  reg [15:0] err_code;
  reg err_push;
  reg q_pop;
  reg aw_got_reg;
  reg w_got_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire [15:0] q_head;
  wire q_nonempty;
  wire q_new;
  wire waiting;
  wire running;
  wire start;
  wire [1:0] src;
  wire [16:0] product;
  wire is_arm;
  wire trg_fire;
  wire math_bad;
  wire q_clr;
  wire halt;
  wire done;
  wire do_write;
  wire [31:0] cfg_wmask;
  wire [31:0] cfg_cand;

  assign src = cfg_reg[`CFG_SRC_MSB:`CFG_SRC_LSB];
  assign product = cfg_reg[`CFG_SCNT_MSB:`CFG_SCNT_LSB] * cfg_reg[`CFG_TCNT_MSB:`CFG_TCNT_LSB];
  assign is_arm = cmd_stb_reg && (cmd_code_reg == `CMD_INIT || cmd_code_reg == `CMD_READ ||
                  cmd_code_reg == `CMD_MEAS);
  assign q_clr = cmd_stb_reg && cmd_code_reg == `CMD_CLS;
  assign halt = cmd_stb_reg && cmd_code_reg == `CMD_DCL;
  assign done = cmd_stb_reg && cmd_code_reg == `CMD_DONE;

  ////////////////////////////////////////////////////////////////////////
  // source selection
  // trigger gated by the wait state inside trig_ctrl
  assign trg_fire = waiting && ((src == `SRC_IMM) ||
                    (src == `SRC_EXT && ext_trig_i) ||
                    (src == `SRC_BUS && cmd_stb_reg && cmd_code_reg == `CMD_TRG));

  trig_ctrl u_trig (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .arm_i(is_arm && !err_push),
    .halt_i(halt),
    .trig_i(trg_fire),
    .done_i(done),
    .waiting_o(waiting),
    .running_o(running),
    .start_o(start)
  );

  err_queue u_queue (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .clr_i(q_clr),
    .push_i(err_push),
    .code_i(err_code),
    .pop_i(q_pop),
    .head_o(q_head),
    .nonempty_o(q_nonempty),
    .new_err_o(q_new)
  );

  ////////////////////////////////////////////////////////////////////////
  // Error detection; one error per command, first match wins
  always @* begin
    err_code = `ERR_NONE;
    err_push = 1'b0;
    if (cmd_stb_reg) begin
      case (cmd_code_reg)
        `CMD_READ: begin
          if (cfg_reg[`CFG_LOCAL_BIT]) begin
            err_code = `ERR_LOCAL;
            err_push = 1'b1;
          end else if (src == `SRC_BUS) begin
            err_code = `ERR_TRG_DEADLOCK;
            err_push = 1'b1;
          end else if (running) begin
            err_code = `ERR_INIT_IGN;
            err_push = 1'b1;
          end else if (out_pend_reg) begin
            err_code = `ERR_Q_INTR;
            err_push = 1'b1;
          end
        end
        `CMD_INIT, `CMD_MEAS: begin
          if (running) begin
            err_code = `ERR_INIT_IGN;
            err_push = 1'b1;
          end else if (cmd_code_reg == `CMD_INIT && product > `MEM_READINGS) begin
            err_code = `ERR_NO_MEM;
            err_push = 1'b1;
          end else if (cmd_code_reg == `CMD_MEAS && out_pend_reg) begin
            err_code = `ERR_Q_INTR;
            err_push = 1'b1;
          end
        end
        `CMD_TRG: begin
          if (!(waiting && src == `SRC_BUS)) begin
            err_code = `ERR_TRG_IGN;
            err_push = 1'b1;
          end
        end
        `CMD_FETCH: begin
          if (mem_cnt_reg == 10'd0) begin
            err_code = `ERR_STALE;
            err_push = 1'b1;
          end else if (out_pend_reg) begin
            err_code = `ERR_Q_INTR;
            err_push = 1'b1;
          end
        end
        `CMD_QUERY: begin
          if (out_pend_reg) begin
            err_code = `ERR_Q_INTR;
            err_push = 1'b1;
          end
        end
        `CMD_TALK: begin
          if (!out_pend_reg) begin
            err_code = `ERR_Q_UNTERM;
            err_push = 1'b1;
          end
        end
        `CMD_BIGOUT: begin
          if (in_buf_full_i) begin
            err_code = `ERR_Q_DEADLOCK;
            err_push = 1'b1;
          end
        end
        `CMD_NULLREF: begin
          if (cmd_arg_reg[0]) begin
            err_code = `ERR_OVLD_REF;
            err_push = 1'b1;
          end
        end
        `CMD_EXPO: begin
          if (cmd_arg_reg[15:0] > `EXP_LIMIT) begin
            err_code = `ERR_OVERFLOW_NUM;
            err_push = 1'b1;
          end
        end
        `CMD_CONF: begin
          if (cfg_reg[`CFG_AUTORANGE_BIT] && cfg_reg[`CFG_FIXRES_BIT]) begin
            err_code = `ERR_CONFLICT;
            err_push = 1'b1;
          end
        end
        default: begin
          err_push = 1'b0;
        end
      endcase
    end
    if (math_bad && !err_push) begin
      err_code = `ERR_CONFLICT;
      err_push = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // math op not valid for function: write taken with math enable cleared, conflict error queued
  assign cfg_wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign cfg_cand = (cfg_reg & ~cfg_wmask) | (w_data_reg & cfg_wmask);
  assign math_bad = do_write && aw_addr_reg == `REG_CFG_OFS && cfg_cand[`CFG_MATH_EN_BIT] &&
                    (cfg_cand[`CFG_FUNC_MSB:`CFG_FUNC_LSB] == `FUNC_CONT ||
                     cfg_cand[`CFG_FUNC_MSB:`CFG_FUNC_LSB] == `FUNC_DIODE ||
                     ((cfg_cand[`CFG_MATH_OP_MSB:`CFG_MATH_OP_LSB] == `MATH_DB ||
                       cfg_cand[`CFG_MATH_OP_MSB:`CFG_MATH_OP_LSB] == `MATH_DBM) &&
                      cfg_cand[`CFG_FUNC_MSB:`CFG_FUNC_LSB] > 4'h4));

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      cfg_reg <= `CFG_RESET;
      cmd_stb_reg <= 1'b0;
      cmd_code_reg <= `CMD_NONE;
      cmd_arg_reg <= 32'h0000_0000;
    end else begin
      cmd_stb_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_got_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_got_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        if (aw_addr_reg == `REG_CMD_OFS) begin
          cmd_stb_reg <= w_strb_reg[0];
          cmd_code_reg <= w_data_reg[`CMD_CODE_MSB:0];
          cmd_arg_reg <= {16'h0000, w_data_reg[31:16]};
          cmd_arg_reg[0] <= w_data_reg[`CMD_ARG_BIT] | w_data_reg[16];
        end else if (aw_addr_reg == `REG_CFG_OFS) begin
          cfg_reg <= cfg_cand;
          if (math_bad) begin
            cfg_reg[`CFG_MATH_EN_BIT] <= 1'b0;
          end
        end else if (aw_addr_reg != `REG_STATUS_OFS && aw_addr_reg != `REG_ERRQ_OFS) begin
          s_axi_bresp <= 2'b10;
        end
      end
      if (cmd_stb_reg && cmd_code_reg == `CMD_NULLREF && cmd_arg_reg[0]) begin
        cfg_reg[`CFG_MATH_EN_BIT] <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read; reading the queue register pops one entry
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      q_pop <= 1'b0;
    end else begin
      q_pop <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `REG_CMD_OFS: begin
            s_axi_rdata <= {28'h0000000, cmd_code_reg};
          end
          `REG_CFG_OFS: begin
            s_axi_rdata <= cfg_reg;
          end
          `REG_STATUS_OFS: begin
            s_axi_rdata <= {16'h0000, mem_cnt_reg, 2'b00, out_pend_reg, q_nonempty,
                            running, waiting};
          end
          `REG_ERRQ_OFS: begin
            s_axi_rdata <= {{16{q_head[15]}}, q_head};
            q_pop <= 1'b1;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reading memory and output buffer bookkeeping
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_cnt_reg <= 10'd0;
      out_pend_reg <= 1'b0;
      meas_direct_reg <= 1'b0;
      err_lamp_o <= 1'b0;
      beep_o <= 1'b0;
      meas_start_o <= 1'b0;
      to_output_o <= 1'b0;
    end else begin
      err_lamp_o <= q_nonempty;
      beep_o <= q_new;
      meas_start_o <= start;
      to_output_o <= start && meas_direct_reg;
      // Set wins over talk
      if (cmd_stb_reg && (cmd_code_reg == `CMD_TALK || cmd_code_reg == `CMD_BIGOUT ||
          cmd_code_reg == `CMD_DCL)) begin
        out_pend_reg <= 1'b0;
      end
      if (is_arm && !err_push) begin
        meas_direct_reg <= (cmd_code_reg != `CMD_INIT);
        if (cmd_code_reg == `CMD_INIT) begin
          mem_cnt_reg <= 10'd0;
        end
      end
      if (start) begin
        if (meas_direct_reg) begin
          out_pend_reg <= 1'b1;
        end else if (mem_cnt_reg != 10'd512) begin
          mem_cnt_reg <= mem_cnt_reg + 10'd1;
        end
      end
      if (cmd_stb_reg && cmd_code_reg == `CMD_FETCH && mem_cnt_reg != 10'd0) begin
        mem_cnt_reg <= 10'd0;
        out_pend_reg <= 1'b1;
      end
      if (cmd_stb_reg && cmd_code_reg == `CMD_QUERY) begin
        out_pend_reg <= 1'b1;
      end
    end
  end
endmodule

// file: sim/remote_cmd_sva.sv
// Port checker of the remote command block, bound into its top module.
// Assumes one clock, an async active-low reset and one bus transfer per kind.
`timescale 1ns/1ps
module remote_cmd_sva (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire err_lamp_o,
  input wire beep_o,
  input wire meas_start_o,
  input wire to_output_o
);
  reg [3:0] since_b_reg;
  reg [3:0] since_r_reg;
  wire [3:0] since_b_next;
  wire [3:0] since_r_next;
  // Saturating ages of the last handshakes, so old causes never wrap
  assign since_b_next = (s_axi_bvalid && s_axi_bready) ? 4'h0 :
    since_b_reg + {3'h0, since_b_reg != 4'hF};
  assign since_r_next = (s_axi_rvalid && s_axi_rready) ? 4'h0 :
    since_r_reg + {3'h0, since_r_reg != 4'hF};
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      since_b_reg <= 4'hF;
      since_r_reg <= 4'hF;
    end else begin
      since_b_reg <= since_b_next;
      since_r_reg <= since_r_next;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  chk_r_stands: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_b_stands: assert property (s_b_wait |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  chk_beep_single: assert property (beep_o |=> !beep_o)
    else $error("beep longer than one cycle");
  chk_beep_cause: assert property (beep_o |-> since_b_reg inside {[4'h0:4'h1]})
    else $error("beep without a command");
  chk_beep_lamp: assert property (beep_o |-> ##[0:1] err_lamp_o)
    else $error("lamp dark after error");
  chk_lamp_fall: assert property ($fell(err_lamp_o) |->
    since_r_reg < 4'h6 || since_b_reg < 4'h9)
    else $error("lamp off without read or clear");
  chk_start_pulse: assert property (meas_start_o |=> !meas_start_o)
    else $error("second start without trigger");
  chk_direct_out: assert property (to_output_o |-> meas_start_o)
    else $error("direct output without start");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind remote_cmd_error_trigger remote_cmd_sva remote_cmd_sva_inst (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .err_lamp_o(err_lamp_o),
  .beep_o(beep_o), .meas_start_o(meas_start_o), .to_output_o(to_output_o)
);

// file: sim/axi_lite_master.sv
// Bus controller model: AXI4-Lite master with one write and one read task.
// Assumes the slave answers in its own time; the bench timeout ends a hang.
`timescale 1ns/1ps
module axi_lite_master (
  input wire clk_sys_i,
  output logic [3:0] awaddr_o,
  output logic awvalid_o,
  input wire awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire wready_i,
  input wire bvalid_i,
  output logic bready_o,
  output logic [3:0] araddr_o,
  output logic arvalid_o,
  input wire arready_i,
  input wire rvalid_i,
  output logic rready_o
);
  initial {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
  // Released lines show inverted values so stale payloads cannot match
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
    end while (!bvalid_i);
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
    end while (!rvalid_i);
    rready_o <= 1'b0;
  endtask
endmodule

// file: sim/remote_cmd_error_trigger_tb.sv
// Self-checking bench of the remote command block.
// Assumes the bus controller model and the bound port checker.
`timescale 1ns/1ps
`include "remote_cmd_map.vh"
module remote_cmd_error_trigger_tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ext_trig_i = 1'b0;
  logic in_buf_full_i = 1'b0;
  wire [3:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  wire lamp, beep, start, direct;
  logic [33:0] exp_q[$];
  logic [15:0] mq[$];
  logic last_direct = 1'b0;
  int fails = 0;
  int tests_run = 0;
  int beeps = 0;
  int eb = 0;
  int starts = 0;
  int cyc = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  remote_cmd_error_trigger remote_cmd_error_trigger_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trig_i(ext_trig_i), .in_buf_full_i(in_buf_full_i), .err_lamp_o(lamp),
    .beep_o(beep), .meas_start_o(start), .to_output_o(direct));
  axi_lite_master axi_lite_master_inst (
    .clk_sys_i(clk_sys_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rvalid_i(rvalid), .rready_o(rready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fails++;
      stop_test();
    end
    if (beep) beeps <= beeps + 1;
    if (start) starts <= starts + 1;
    if (start) last_direct <= direct;
    if (rvalid && rready) chk(exp_q.pop_front(), {rresp, rdata});
  end
  task automatic cmd(input logic [3:0] c, input logic [15:0] arg);
    axi_lite_master_inst.wr(`REG_CMD_OFS, {arg, 12'h000, c});
    repeat (5) @(posedge clk_sys_i);
  endtask
  task automatic cfg(input logic [31:0] d);
    axi_lite_master_inst.wr(`REG_CFG_OFS, d);
    repeat (5) @(posedge clk_sys_i);
  endtask
  task automatic expect_err(input logic [15:0] c);
    // Model queue: full queue keeps -350 in its newest slot
    if (mq.size() < `QUEUE_DEPTH) mq.push_back(c);
    else mq[`QUEUE_DEPTH-1] = `ERR_TOO_MANY;
    eb++;
    chk(34'h1, {33'h0, lamp});
    chk(34'(eb), 34'(beeps));
  endtask
  task automatic pop_one;
    logic [15:0] c;
    c = mq.pop_front();
    exp_q.push_back({2'b00, {16{c[15]}}, c});
    axi_lite_master_inst.rd(`REG_ERRQ_OFS);
  endtask
  task automatic drain(input string name);
    while (mq.size() > 0) pop_one();
    exp_q.push_back(34'h0);
    axi_lite_master_inst.rd(`REG_ERRQ_OFS);
    repeat (3) @(posedge clk_sys_i);
    chk(34'h0, {33'h0, lamp});
    $display("test %s done", name);
  endtask
  task automatic chk_start(input int n, input logic d);
    chk(34'(n), 34'(starts));
    if (n > 0) chk({33'h0, d}, {33'h0, last_direct});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6b79abf5));
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    drain("power_up");
    cmd(`CMD_FETCH, 16'h0000); expect_err(`ERR_STALE);
    cfg(32'h0000_0001);
    cmd(`CMD_TRG, 16'h0000); expect_err(`ERR_TRG_IGN);
    cmd(`CMD_READ, 16'h0000); expect_err(`ERR_TRG_DEADLOCK);
    cmd(`CMD_DCL, 16'h0000);
    cfg(32'h0000_1002);
    cmd(`CMD_READ, 16'h0000); expect_err(`ERR_LOCAL);
    cfg(32'h0000_6002); cmd(`CMD_CONF, 16'h0000); expect_err(`ERR_CONFLICT);
    cfg(32'h0000_0804); expect_err(`ERR_CONFLICT);
    cmd(`CMD_TALK, 16'h0000); expect_err(`ERR_Q_UNTERM);
    cmd(`CMD_BIGOUT, 16'h0000);
    @(posedge clk_sys_i) in_buf_full_i <= 1'b1;
    cmd(`CMD_BIGOUT, 16'h0000); expect_err(`ERR_Q_DEADLOCK);
    @(posedge clk_sys_i) in_buf_full_i <= 1'b0;
    cmd(`CMD_NULLREF, 16'h0000);
    cmd(`CMD_NULLREF, 16'h0001); expect_err(`ERR_OVLD_REF);
    cmd(`CMD_EXPO, `EXP_LIMIT);
    cmd(`CMD_EXPO, `EXP_LIMIT + 16'd1 + 16'($urandom % 500)); expect_err(`ERR_OVERFLOW_NUM);
    cfg(32'h1020_0001);
    cmd(`CMD_INIT, 16'h0000);
    cmd(`CMD_DCL, 16'h0000);
    cfg(32'h1120_0001);
    cmd(`CMD_INIT, 16'h0000); expect_err(`ERR_NO_MEM);
    cmd(`CMD_DCL, 16'h0000);
    drain("error_codes");
    cfg(32'h0101_0002);
    @(posedge clk_sys_i) ext_trig_i <= 1'b1;
    repeat (3 + $urandom % 8) @(posedge clk_sys_i);
    chk_start(0, 1'b0);
    cmd(`CMD_INIT, 16'h0000); chk_start(1, 1'b0);
    cmd(`CMD_INIT, 16'h0000); expect_err(`ERR_INIT_IGN);
    cmd(`CMD_DCL, 16'h0000);
    cmd(`CMD_INIT, 16'h0000); chk_start(2, 1'b0);
    cmd(`CMD_DONE, 16'h0000);
    @(posedge clk_sys_i) ext_trig_i <= 1'b0;
    cmd(`CMD_FETCH, 16'h0000);
    cmd(`CMD_TALK, 16'h0000);
    cfg(32'h0101_0000);
    cmd(`CMD_READ, 16'h0000); chk_start(3, 1'b1);
    cmd(`CMD_DONE, 16'h0000);
    cmd(`CMD_TALK, 16'h0000);
    cmd(`CMD_MEAS, 16'h0000); chk_start(4, 1'b1);
    cmd(`CMD_DONE, 16'h0000);
    cmd(`CMD_TALK, 16'h0000);
    cmd(`CMD_QUERY, 16'h0000);
    cmd(`CMD_QUERY, 16'h0000); expect_err(`ERR_Q_INTR);
    cmd(`CMD_TALK, 16'h0000);
    cmd(`CMD_RST, 16'h0000);
    drain("trigger");
    cfg(32'h0000_0001);
    cmd(`CMD_INIT, 16'h0000); cmd(`CMD_TRG, 16'h0000); chk_start(5, 1'b0);
    cmd(`CMD_DONE, 16'h0000);
    repeat (22) begin
      cmd(`CMD_TRG, 16'h0000); expect_err(`ERR_TRG_IGN);
    end
    pop_one();
    cmd(`CMD_TRG, 16'h0000); expect_err(`ERR_TRG_IGN);
    drain("overflow");
    cmd(`CMD_TRG, 16'h0000); expect_err(`ERR_TRG_IGN);
    cmd(`CMD_CLS, 16'h0000);
    mq.delete();
    drain("clear_status");
    stop_test();
  end
endmodule
